// >>> jts_defines.svh
// Constants for the boundary-scan test access logic
`ifndef JTS_DEFINES_SVH
`define JTS_DEFINES_SVH

`define JTS_IR_LEN 3
`define JTS_IR_EXTEST 3'h0
`define JTS_IR_IDCODE 3'h1
`define JTS_IR_SAMPZ 3'h2
`define JTS_IR_SAMPLE 3'h4
`define JTS_IR_BYPASS 3'h7
`define JTS_IR_CAPT 3'h1
`define JTS_BSR_LEN 107
`define JTS_N_DQ 36
`define JTS_CTRL_POS 48
`define JTS_ID_LEN 32
// Arbitrary identification value, bit 0 kept at one
`define JTS_ID_CODE 32'h0000_0A01
`define JTS_TLR_ONES 5

`endif

// >>> jts_pkg.sv
// Types for the boundary-scan test access logic
package jts_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jts_state_type;

    typedef struct packed {
        logic data;
        logic oe;
    } jts_tdo_type;

endpackage : jts_pkg

// >>> jts_fifo2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module jts_fifo2 #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    if (WIDTH < 1) begin : g_bad_width
        $error("jts_fifo2: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    fill_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
        count_reg <= 2'h2) else $error("buffer count above two");
endmodule : jts_fifo2

// >>> jts_sram_scan.sv
// Boundary-scan test access logic of a DDR SRAM, sampled on sys_clk
`timescale 1ns/1ps
`include "jts_defines.svh"

module jts_sram_scan #(
    parameter int BSR_LEN = `JTS_BSR_LEN,
    parameter int N_DQ = `JTS_N_DQ,
    parameter int CTRL_POS = `JTS_CTRL_POS,
    parameter logic [`JTS_ID_LEN-1:0] ID_CODE = `JTS_ID_CODE
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [N_DQ-1:0] sram_q,
    input wire logic sram_read,
    input wire logic sram_echo,
    input wire logic sram_echo_n,
    input wire logic [N_DQ-1:0] dq_pad_in,
    input wire logic [1:0] echo_pad_in,
    input wire logic [BSR_LEN-N_DQ-4:0] func_in,
    output logic tdo,
    output logic tdo_oe,
    output logic [N_DQ-1:0] dq_out,
    output logic [N_DQ-1:0] dq_oe,
    output logic echo_clock_out,
    output logic echo_clock_out_n,
    output logic echo_oe
);
    localparam int N_IN = BSR_LEN - N_DQ - 3;
    localparam int SW = 8 + 2 * N_DQ + N_IN;
    localparam int IRL = `JTS_IR_LEN;
    localparam int IDL = `JTS_ID_LEN;
    if (N_DQ < 1 || CTRL_POS < N_DQ + 2 || CTRL_POS >= BSR_LEN ||
        N_IN < 1) begin : g_bad_layout
        $error("jts_sram_scan: boundary layout does not fit BSR_LEN");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Every pin and every memory-side signal is foreign to sys_clk
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic tck_d_reg;
    wire [SW-1:0] raw = {sram_read, sram_echo_n, sram_echo, sram_q,
                         dq_pad_in, echo_pad_in, func_in, tdi, tms, tck};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_d_reg <= 1'b0;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            tck_d_reg <= sync2_reg[0];
        end
    end

    wire tck_s = sync2_reg[0];
    wire tms_s = sync2_reg[1];
    wire tdi_s = sync2_reg[2];
    wire [N_IN-1:0] in_s = sync2_reg[3 +: N_IN];
    wire [1:0] epad_s = sync2_reg[3 + N_IN +: 2];
    wire [N_DQ-1:0] dpad_s = sync2_reg[5 + N_IN +: N_DQ];
    wire [N_DQ-1:0] q_s = sync2_reg[5 + N_IN + N_DQ +: N_DQ];
    wire [1:0] eint_s = sync2_reg[SW-3 +: 2];
    wire read_s = sync2_reg[SW-1];
    wire rise = tck_s && !tck_d_reg;
    wire fall = !tck_s && tck_d_reg;

    // ------------------------------------------------------------
    // TAP state machine
    // ------------------------------------------------------------
    function automatic jts_pkg::jts_state_type tap_next(
        input jts_pkg::jts_state_type s, input logic m);
        case (s)
            jts_pkg::TLR: tap_next = m ? jts_pkg::TLR : jts_pkg::RTI;
            jts_pkg::RTI: tap_next = m ? jts_pkg::SEL_DR : jts_pkg::RTI;
            jts_pkg::SEL_DR: tap_next = m ? jts_pkg::SEL_IR : jts_pkg::CAP_DR;
            jts_pkg::CAP_DR: tap_next = m ? jts_pkg::EX1_DR : jts_pkg::SH_DR;
            jts_pkg::SH_DR: tap_next = m ? jts_pkg::EX1_DR : jts_pkg::SH_DR;
            jts_pkg::EX1_DR: tap_next = m ? jts_pkg::UPD_DR : jts_pkg::PAU_DR;
            jts_pkg::PAU_DR: tap_next = m ? jts_pkg::EX2_DR : jts_pkg::PAU_DR;
            jts_pkg::EX2_DR: tap_next = m ? jts_pkg::UPD_DR : jts_pkg::SH_DR;
            jts_pkg::UPD_DR: tap_next = m ? jts_pkg::SEL_DR : jts_pkg::RTI;
            jts_pkg::SEL_IR: tap_next = m ? jts_pkg::TLR : jts_pkg::CAP_IR;
            jts_pkg::CAP_IR: tap_next = m ? jts_pkg::EX1_IR : jts_pkg::SH_IR;
            jts_pkg::SH_IR: tap_next = m ? jts_pkg::EX1_IR : jts_pkg::SH_IR;
            jts_pkg::EX1_IR: tap_next = m ? jts_pkg::UPD_IR : jts_pkg::PAU_IR;
            jts_pkg::PAU_IR: tap_next = m ? jts_pkg::EX2_IR : jts_pkg::PAU_IR;
            jts_pkg::EX2_IR: tap_next = m ? jts_pkg::UPD_IR : jts_pkg::SH_IR;
            default: tap_next = m ? jts_pkg::SEL_DR : jts_pkg::RTI;
        endcase
    endfunction : tap_next
    jts_pkg::jts_state_type state_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= jts_pkg::TLR;
        end else if (rise) begin
            state_reg <= tap_next(state_reg, tms_s);
        end
    end
    wire cap_dr = rise && state_reg == jts_pkg::CAP_DR;
    wire sh_dr = rise && state_reg == jts_pkg::SH_DR;
    wire upd_dr = fall && state_reg == jts_pkg::UPD_DR;
    wire cap_ir = rise && state_reg == jts_pkg::CAP_IR;
    wire sh_ir = rise && state_reg == jts_pkg::SH_IR;
    wire upd_ir = fall && state_reg == jts_pkg::UPD_IR;
    // ------------------------------------------------------------
    // Instruction register and decode
    // ------------------------------------------------------------
    logic [IRL-1:0] ir_reg;
    logic [IRL-1:0] ir_sh_reg;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ir_reg <= `JTS_IR_IDCODE;
            ir_sh_reg <= '0;
        end else begin
            if (state_reg == jts_pkg::TLR) begin
                ir_reg <= `JTS_IR_IDCODE;
            end else if (upd_ir) begin
                ir_reg <= ir_sh_reg;
            end
            if (cap_ir) begin
                ir_sh_reg <= `JTS_IR_CAPT;
            end else if (sh_ir) begin
                ir_sh_reg <= {tdi_s, ir_sh_reg[IRL-1:1]};
            end
        end
    end
    // Reserved codes fall through to the bypass path
    wire is_ext = ir_reg == `JTS_IR_EXTEST;
    wire is_idc = ir_reg == `JTS_IR_IDCODE;
    wire is_sz = ir_reg == `JTS_IR_SAMPZ;
    wire is_smp = ir_reg == `JTS_IR_SAMPLE;
    wire use_bsr = is_ext || is_sz || is_smp;
    wire use_upd = is_ext || is_smp;
    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    function automatic logic [BSR_LEN-1:0] bsr_pack(
        input logic [N_DQ-1:0] dqv, input logic [1:0] ev,
        input logic [N_IN-1:0] inv, input logic ctl);
        int k;
        k = 0;
        bsr_pack = '0;
        for (int i = 0; i < BSR_LEN; i++) begin
            if (i < N_DQ) begin
                bsr_pack[i] = dqv[i];
            end else if (i < N_DQ + 2) begin
                bsr_pack[i] = ev[i-N_DQ];
            end else if (i == CTRL_POS) begin
                bsr_pack[i] = ctl;
            end else begin
                bsr_pack[i] = inv[k];
                k++;
            end
        end
    endfunction : bsr_pack
    logic [BSR_LEN-1:0] bsr_reg;
    logic [BSR_LEN-1:0] upd_reg;
    logic [IDL-1:0] id_reg;
    logic byp_reg;
    // Sample reads the core while it drives, the pad while it idles
    wire [N_DQ-1:0] dq_cap = (is_smp && read_s) ? q_s : dpad_s;
    wire [1:0] ec_cap = is_smp ? eint_s : epad_s;
    wire [BSR_LEN-1:0] cap_vec =
        bsr_pack(dq_cap, ec_cap, in_s, upd_reg[CTRL_POS]);
    wire ctrl = upd_reg[CTRL_POS];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bsr_reg <= '0;
            upd_reg <= '0;
            id_reg <= '0;
            byp_reg <= 1'b0;
        end else begin
            if (cap_dr && use_bsr) begin
                bsr_reg <= cap_vec;
            end else if (sh_dr && use_bsr) begin
                bsr_reg <= {tdi_s, bsr_reg[BSR_LEN-1:1]};
            end
            if (upd_dr && use_upd) begin
                upd_reg <= bsr_reg;
            end
            if (cap_dr && is_idc) begin
                id_reg <= ID_CODE;
            end else if (sh_dr && is_idc) begin
                id_reg <= {tdi_s, id_reg[IDL-1:1]};
            end
            if (cap_dr) begin
                byp_reg <= 1'b0;
            end else if (sh_dr) begin
                byp_reg <= tdi_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    wire [N_DQ-1:0] dq_nx = is_ext ? upd_reg[N_DQ-1:0] : q_s;
    wire [N_DQ-1:0] dq_oe_nx =
        is_ext ? {N_DQ{ctrl}} : (is_sz ? '0 : {N_DQ{read_s}});
    wire [1:0] ec_nx = is_ext ? upd_reg[N_DQ +: 2] : eint_s;
    wire ec_oe_nx = !is_sz;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dq_out <= '0;
            dq_oe <= '0;
            echo_clock_out <= 1'b0;
            echo_clock_out_n <= 1'b0;
            echo_oe <= 1'b0;
        end else begin
            dq_out <= dq_nx;
            dq_oe <= dq_oe_nx;
            echo_clock_out <= ec_nx[0];
            echo_clock_out_n <= ec_nx[1];
            echo_oe <= ec_oe_nx;
        end
    end

    // ------------------------------------------------------------
    // TDO path through the two-entry buffer
    // ------------------------------------------------------------
    // The bit is sampled one cycle after the rising edge so that the
    // shifted register is seen; the falling edge drains it to the pin.
    jts_pkg::jts_tdo_type tdo_src;
    jts_pkg::jts_tdo_type tdo_buf;
    jts_pkg::jts_tdo_type tdo_reg;
    logic pend_reg;
    logic buf_ready;
    logic buf_valid;
    wire dr_bit = use_bsr ? bsr_reg[0] : (is_idc ? id_reg[0] : byp_reg);

    assign tdo_src.oe = state_reg == jts_pkg::SH_DR ||
                        state_reg == jts_pkg::SH_IR;
    assign tdo_src.data = state_reg == jts_pkg::SH_IR ? ir_sh_reg[0] : dr_bit;

    jts_fifo2 #(.WIDTH(2)) u_tdo_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_data(tdo_src),
        .in_valid(pend_reg),
        .in_ready(buf_ready),
        .out_data(tdo_buf),
        .out_valid(buf_valid),
        .out_ready(fall)
    );

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
            tdo_reg <= '0;
        end else begin
            pend_reg <= rise || (pend_reg && !buf_ready);
            if (fall && buf_valid) begin
                tdo_reg <= tdo_buf;
            end
        end
    end

    assign tdo = tdo_reg.data;
    assign tdo_oe = tdo_reg.oe;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_cap(logic sel);
        cap_dr && sel;
    endsequence
    sequence s_upd;
        upd_dr && use_upd;
    endsequence

    bypass_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
        sh_dr && ir_reg == `JTS_IR_BYPASS |=> byp_reg == $past(tdi_s))
        else $error("bypass bit not shifted from tdi");
    sample_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_cap(is_smp) |=> bsr_reg == $past(cap_vec))
        else $error("sample capture missed pins");
    sample_shift_a: assert property (@(posedge sys_clk) disable iff (rst)
        sh_dr && use_bsr |=> bsr_reg[BSR_LEN-1] == $past(tdi_s))
        else $error("boundary register not in shift path");
    sampz_float_a: assert property (@(posedge sys_clk) disable iff (rst)
        is_sz |=> dq_oe == '0 && !echo_oe)
        else $error("tristate-sample left a pin driven");
    extest_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
        is_ext |=> dq_oe == {N_DQ{$past(ctrl)}} && echo_oe &&
        dq_out == $past(upd_reg[N_DQ-1:0]))
        else $error("extest drive not following control bit");
    normal_path_a: assert property (@(posedge sys_clk) disable iff (rst)
        !is_ext && !is_sz |=> dq_out == $past(q_s) &&
        echo_clock_out == $past(eint_s[0]))
        else $error("normal output not passed through");
    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(ctrl) |-> $past(upd_dr && use_upd))
        else $error("control bit changed outside update");
    ctrl_take_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_upd |=> ctrl == $past(bsr_reg[CTRL_POS]))
        else $error("control bit not taken at update");
    sampz_pad_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_cap(is_sz) |=> bsr_reg[N_DQ-1:0] == $past(dpad_s))
        else $error("tristate-sample did not capture pads");
    idcode_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        s_cap(is_idc) |=> id_reg == ID_CODE)
        else $error("identification value not captured");
    tlr_default_a: assert property (@(posedge sys_clk) disable iff (rst)
        state_reg == jts_pkg::TLR |=> ir_reg == `JTS_IR_IDCODE)
        else $error("idcode not default in reset state");
    tap_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
        rise && tms_s && state_reg == jts_pkg::SEL_IR |=>
        state_reg == jts_pkg::TLR)
        else $error("tap did not reach reset state");
    tdo_fall_a: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(tdo_reg) |-> $past(fall))
        else $error("tdo changed off a falling edge");
endmodule : jts_sram_scan

// >>> jts_jtag_ctl.sv
// Behavioural test controller that drives the scan link
`timescale 1ns/1ps
module jts_jtag_ctl (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ----------------------------------------
    // Link cycle
    // ----------------------------------------
    // Test clock stands low between frames; tdo is taken late in the
    // high phase, where the value launched by the last fall still stands
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #100 tck = 1'b1;
        #95 q = tdo;
        #5 tck = 1'b0;
    endtask : step

    // Five ones reach test-logic-reset from any state, then idle
    task automatic tlr();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : tlr

    // Scan from run-test-idle back to run-test-idle, LSB first
    task automatic scan(input bit ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : jts_jtag_ctl

// >>> test_sram_jtag_boundary_scan.sv
// Self-checking bench for the boundary-scan test access logic
`timescale 1ns/1ps
`include "jts_defines.svh"
module test_sram_jtag_boundary_scan;
    logic sys_clk, rst, tck, tms, tdi, tdo, tdo_oe, ctl;
    logic sram_read, sram_echo, sram_echo_n, echo_clock_out;
    logic echo_clock_out_n, echo_oe;
    logic [35:0] sram_q, dq_pad_in, dq_out, dq_oe;
    logic [1:0] echo_pad_in;
    logic [67:0] func_in;
    logic [127:0] din, dout, upd;
    int n_mismatch = 0;
    int samples_checked = 0;
    int oe_seen = 0;

    jts_sram_scan uut (.sys_clk, .rst, .tck, .tms, .tdi, .sram_q, .sram_read,
        .sram_echo, .sram_echo_n, .dq_pad_in, .echo_pad_in, .func_in, .tdo,
        .tdo_oe, .dq_out, .dq_oe, .echo_clock_out, .echo_clock_out_n,
        .echo_oe);
    jts_jtag_ctl link (.tck, .tms, .tdi, .tdo);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Counts link clocks that find tdo driven, one per shifted bit
    always @(posedge tck) begin
        if (tdo_oe === 1'b1) begin
            oe_seen++;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [127:0] got, exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg,
                     got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // Expected boundary image: data, echo pair, inputs around the control
    function automatic logic [127:0] bsr(input logic [35:0] dq,
                                         input logic [1:0] ec, input logic c);
        logic [127:0] v;
        v = '0;
        v[35:0] = dq;
        v[37:36] = ec;
        v[47:38] = func_in[9:0];
        v[48] = c;
        v[106:49] = func_in[67:10];
        return v;
    endfunction : bsr

    // Memory side only changes while the link stands still, so no
    // capture ever samples a moving input
    task automatic drive_mem(input logic rd);
        @(posedge sys_clk);
        #2;
        sram_q = 36'({$urandom, $urandom});
        dq_pad_in = 36'({$urandom, $urandom});
        func_in = 68'({$urandom, $urandom, $urandom});
        echo_pad_in = 2'($urandom);
        sram_echo = 1'($urandom);
        sram_echo_n = 1'($urandom);
        sram_read = rd;
        repeat (10) @(posedge sys_clk);
    endtask : drive_mem

    // Reserved codes are never loaded
    task automatic ld(input logic [2:0] c);
        oe_seen = 0;
        link.scan(1'b1, 3, 128'(c), dout);
        check(dout, 128'h1, "ir capture");
        check(128'(oe_seen), 128'h3, "ir tdo enable");
        repeat (20) @(posedge sys_clk);
    endtask : ld

    task automatic dr(input int n);
        oe_seen = 0;
        link.scan(1'b0, n, din, dout);
        check(128'(oe_seen), 128'(n), "dr tdo enable");
        repeat (20) @(posedge sys_clk);
    endtask : dr

    // Mode 0 memory path, 1 boundary drive, 2 floating
    task automatic outs(input int m);
        logic [74:0] e;
        e = {1'b1, sram_echo_n, sram_echo, {36{sram_read}}, sram_q};
        if (m == 1) e = {1'b1, upd[37:36], {36{ctl}}, upd[35:0]};
        if (m == 2) begin
            check(128'({echo_oe, dq_oe}), 128'h0, "float");
        end else begin
            check(128'({echo_oe, echo_clock_out_n, echo_clock_out, dq_oe,
                        dq_out}), 128'(e), "drive");
        end
    endtask : outs

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {sram_read, sram_echo, sram_echo_n, echo_pad_in} = '0;
        {sram_q, dq_pad_in, func_in} = '0;
        ctl = 1'b0;
        upd = '0;
        void'($urandom(32'h7F7F));
        repeat (8) @(posedge sys_clk);
        #2 rst = 1'b0;
        drive_mem(1'b1);
        outs(0);
        link.tlr();
        din = {$urandom, $urandom, $urandom, $urandom};
        dr(32);
        check(dout, 128'(`JTS_ID_CODE), "id after reset");
        ld(`JTS_IR_BYPASS);
        dr(9);
        check(dout, 128'({din[7:0], 1'b0}), "bypass");
        outs(0);
        for (int r = 0; r < 2; r++) begin
            drive_mem(r[0]);
            ld(`JTS_IR_SAMPLE);
            din = {$urandom, $urandom, $urandom, $urandom};
            din[48] = r[0];
            dr(107);
            check(dout, bsr(r ? sram_q : dq_pad_in,
                  {sram_echo_n, sram_echo}, ctl), "sample");
            upd = din;
            ctl = din[48];
            outs(0);
            ld(`JTS_IR_EXTEST);
            outs(1);
            drive_mem(~r[0]);
            din = {$urandom, $urandom, $urandom, $urandom};
            dr(107);
            check(dout, bsr(dq_pad_in, echo_pad_in, ctl), "extest");
            upd = din;
            ctl = din[48];
            outs(1);
        end
        ld(`JTS_IR_SAMPZ);
        outs(2);
        drive_mem(1'b1);
        din = {$urandom, $urandom, $urandom, $urandom};
        din[48] = ~ctl;
        dr(107);
        check(dout, bsr(dq_pad_in, echo_pad_in, ctl), "tri cap");
        outs(2);
        ld(`JTS_IR_EXTEST);
        outs(1);
        ld(`JTS_IR_IDCODE);
        outs(0);
        link.tlr();
        dr(32);
        check(dout, 128'(`JTS_ID_CODE), "id after tlr");
        outs(0);
        close_out();
    end

    // Whole run is some 160 us of link traffic
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end
endmodule : test_sram_jtag_boundary_scan
